// [crf_pkg.sv]
// Package of constants for the CPU register file and condition-code block.
// Assumes every user imports nothing and writes crf_pkg::name at each use.
//
// Function
// - Addresses live in one 64-kbyte space shared by program and data.
// - Eight identical 32-bit general registers serve as address or data registers.
// - Each general register splits into upper and lower 16-bit halves.
// - Each lower half splits again into a high byte and a low byte.
// - Data accesses choose 32, 16 or 8 bits, chosen per access.
// - Register seven doubles as stack pointer for exceptions and calls.
// - The program counter is 24 bits and points at the next instruction.
// - Fetches treat the program counter's lowest bit as zero.
// - Reset loads the program counter from the reset vector.
// - Flags register is 8 bits; reset sets only its mask bit.
// - Mask bit blocks ordinary interrupts; the non-maskable one always passes.
// - Entering any exception sets the interrupt mask bit.
// - Bit six is a spare user bit, readable and writable by software.
// - Half-carry records carry or borrow out of bit 3, 11 or 27.
// - Some operations keep flags; load, AND, OR, XOR may rewrite them.
// - Conditional branches test the negative, zero, overflow and carry flags.
// - Register add and subtract finish in two states.
// - Byte multiply or divide takes 14 states; word ones take 22.
// - The sleep command puts the processor into its power-down state.
// - Negative holds the result sign; zero flags an all-zero result.
// - Overflow marks arithmetic overflow; carry records carry or borrow.

`default_nettype none

package crf_pkg;

  localparam int unsigned NUM_REGS = 8;
  localparam int unsigned REG_W = 32;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned PC_W = 24;
  localparam int unsigned ADDR_W = 16;
  localparam logic [2:0] SP_INDEX = 3'h7;

  // Access sizes.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Operation codes.
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_CMP = 3'h2;
  localparam logic [2:0] OP_NEG = 3'h3;
  localparam logic [2:0] OP_MUL = 3'h4;
  localparam logic [2:0] OP_DIV = 3'h5;
  localparam logic [2:0] OP_SPINC = 3'h6;
  localparam logic [2:0] OP_SPDEC = 3'h7;

  // Flag-register transfer operations.
  localparam logic [1:0] CC_LOAD = 2'h0;
  localparam logic [1:0] CC_AND = 2'h1;
  localparam logic [1:0] CC_OR = 2'h2;
  localparam logic [1:0] CC_XOR = 2'h3;

  // Flag-register bit positions.
  localparam int unsigned CC_I = 7;
  localparam int unsigned CC_UI = 6;
  localparam int unsigned CC_H = 5;
  localparam int unsigned CC_N = 3;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_C = 0;
  localparam logic [7:0] CC_RESET = 8'h80;

  // Execution lengths in states.
  localparam logic [4:0] STATES_ADDSUB = 5'h02;
  localparam logic [4:0] STATES_MULDIV_BYTE = 5'h0E;
  localparam logic [4:0] STATES_MULDIV_WORD = 5'h16;

  localparam logic [ADDR_W-1:0] RESET_VECTOR_ADDR = 16'h0000;

  typedef enum logic [3:0] {
    ST_VECTOR = 4'b0001,
    ST_IDLE   = 4'b0010,
    ST_EXEC   = 4'b0100,
    ST_SLEEP  = 4'b1000
  } crf_state_e;

endpackage

`default_nettype wire

// [crf_gpr_bank.sv]
// Eight-entry general register bank with byte-lane writes.
// Assumes the owner muxes addresses; read data appear one clock after the index.

`default_nettype none

module crf_gpr_bank (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  // Write port
  input  wire logic [crf_pkg::IDX_W-1:0]      wr_idx,
  input  wire logic [3:0]                     wr_be,
  input  wire logic [crf_pkg::REG_W-1:0]      wr_data,
  // Read ports
  input  wire logic [crf_pkg::IDX_W-1:0]      rd_a_idx,
  input  wire logic [crf_pkg::IDX_W-1:0]      rd_b_idx,
  output logic      [crf_pkg::REG_W-1:0]      rd_a_data,
  output logic      [crf_pkg::REG_W-1:0]      rd_b_data
);

  logic [crf_pkg::REG_W-1:0] regs [crf_pkg::NUM_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < crf_pkg::NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          regs[gi] <= '0;
        end
        else if (wr_idx == gi[crf_pkg::IDX_W-1:0])
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wr_be[b])
            begin
              regs[gi][b*8 +: 8] <= wr_data[b*8 +: 8];
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end
    else
    begin
      rd_a_data <= regs[rd_a_idx];
      rd_b_data <= regs[rd_b_idx];
    end
  end

endmodule

`default_nettype wire

// [crf_alu.sv]
// Combinational arithmetic unit producing a result and the five arithmetic flags.
// Assumes operands arrive zero-extended at the size given.

`default_nettype none

module crf_alu (
  // Operation
  input  wire logic [2:0]                  op,
  input  wire logic [1:0]                  size,
  input  wire logic [crf_pkg::REG_W-1:0]   opa,
  input  wire logic [crf_pkg::REG_W-1:0]   opb,
  // Result and flags
  output logic      [crf_pkg::REG_W-1:0]   result,
  output logic                             flag_h,
  output logic                             flag_n,
  output logic                             flag_z,
  output logic                             flag_v,
  output logic                             flag_c
);

  logic [4:0]  sh;
  logic        is_sub;
  logic [31:0] xa;
  logic [31:0] ya;
  logic [32:0] r33;
  logic [28:0] hs;

  always_comb
  begin
    case (size)
      crf_pkg::SZ_BYTE: sh = 5'd24;
      crf_pkg::SZ_WORD: sh = 5'd16;
      default:          sh = 5'd0;
    endcase
    is_sub = (op == crf_pkg::OP_SUB) || (op == crf_pkg::OP_CMP) ||
             (op == crf_pkg::OP_NEG) || (op == crf_pkg::OP_SPDEC);
    // Operands are shifted so the sign bit sits at bit 31 for every size.
    xa = (op == crf_pkg::OP_NEG) ? 32'h0000_0000 : (opa << sh);
    ya = opb << sh;
    r33 = is_sub ? ({1'b0, xa} - {1'b0, ya}) : ({1'b0, xa} + {1'b0, ya});
    // Bits 3, 11 and 27 of the operand all land at bit 27 once aligned.
    hs = is_sub ? ({1'b0, xa[27:0]} - {1'b0, ya[27:0]})
                : ({1'b0, xa[27:0]} + {1'b0, ya[27:0]});
    flag_h = hs[28];
    flag_n = r33[31];
    flag_z = (r33[31:0] == 32'h0000_0000);
    flag_v = ((xa[31] ^ ya[31]) == is_sub) && (r33[31] != xa[31]);
    flag_c = r33[32];
    case (op)
      crf_pkg::OP_MUL:
      begin
        if (size == crf_pkg::SZ_BYTE)
          result = {16'h0000, 16'(opa[7:0] * opb[7:0])};
        else
          result = 32'(opa[15:0] * opb[15:0]);
      end
      crf_pkg::OP_DIV:
      begin
        if (size == crf_pkg::SZ_BYTE)
          result = (opb[7:0] == 8'h00) ? opa :
                   {16'h0000, 8'(opa[15:0] % {8'h00, opb[7:0]}),
                    8'(opa[15:0] / {8'h00, opb[7:0]})};
        else
          result = (opb[15:0] == 16'h0000) ? opa :
                   {16'(opa % {16'h0000, opb[15:0]}),
                    16'(opa / {16'h0000, opb[15:0]})};
      end
      default: result = r33[31:0] >> sh;
    endcase
  end

endmodule

`default_nettype wire

// [crf_core.sv]
// CPU register resources: general registers, stack pointer, program counter
// and condition-code register, with the operation sequencer that drives them.
// Assumes a sequencer on the same clock issues one request per cycle while idle.

`default_nettype none

module crf_core (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  // Reset vector fetch
  output logic                               vec_req,
  output logic      [crf_pkg::ADDR_W-1:0]    vec_addr,
  input  wire logic                          vec_ack,
  input  wire logic [crf_pkg::PC_W-1:0]      vec_data,
  // Program counter
  input  wire logic                          pc_load,
  input  wire logic [crf_pkg::PC_W-1:0]      pc_target,
  input  wire logic                          pc_step,
  output logic      [crf_pkg::PC_W-1:0]      pc,
  output logic      [crf_pkg::ADDR_W-1:0]    fetch_addr,
  // Direct register access
  input  wire logic                          rd_req,
  input  wire logic [3:0]                    rd_sel,
  input  wire logic [1:0]                    rd_size,
  output logic                               rd_valid,
  output logic      [crf_pkg::REG_W-1:0]     rd_data,
  input  wire logic                          wr_req,
  input  wire logic [3:0]                    wr_sel,
  input  wire logic [1:0]                    wr_size,
  input  wire logic [crf_pkg::REG_W-1:0]     wr_data,
  // Arithmetic and stack operations
  input  wire logic                          op_start,
  input  wire logic [2:0]                    op_code,
  input  wire logic [1:0]                    op_size,
  input  wire logic [3:0]                    op_dst,
  input  wire logic [3:0]                    op_src,
  input  wire logic                          op_use_imm,
  input  wire logic [crf_pkg::REG_W-1:0]     op_imm,
  output logic                               op_done,
  output logic                               busy,
  // Condition-code transfers
  input  wire logic                          cc_wr,
  input  wire logic [1:0]                    cc_op,
  input  wire logic [7:0]                    cc_imm,
  output logic      [7:0]                    condition_code,
  // Branch test
  input  wire logic [3:0]                    branch_cond,
  output logic                               branch_true,
  // Exceptions, interrupts and sleep
  input  wire logic                          exc_entry,
  input  wire logic                          irq_req,
  input  wire logic                          nmi_req,
  output logic                               irq_take,
  input  wire logic                          sleep_cmd,
  output logic                               power_down
);

  crf_pkg::crf_state_e state;
  crf_pkg::crf_state_e next_state;

  logic [4:0]                 cnt;
  logic [2:0]                 cur_op;
  logic [1:0]                 cur_size;
  logic [3:0]                 cur_dst;
  logic [3:0]                 cur_src;
  logic                       cur_imm_sel;
  logic [crf_pkg::REG_W-1:0]  cur_imm;
  logic [3:0]                 rd_sel_q;
  logic [1:0]                 rd_size_q;

  logic [crf_pkg::IDX_W-1:0]  bank_wr_idx;
  logic [3:0]                 bank_wr_be;
  logic [crf_pkg::REG_W-1:0]  bank_wr_data;
  logic [crf_pkg::IDX_W-1:0]  bank_a_idx;
  logic [crf_pkg::IDX_W-1:0]  bank_b_idx;
  logic [crf_pkg::REG_W-1:0]  bank_a_q;
  logic [crf_pkg::REG_W-1:0]  bank_b_q;

  logic [1:0]                 dst_size;
  logic [crf_pkg::REG_W-1:0]  alu_a;
  logic [crf_pkg::REG_W-1:0]  alu_b;
  logic [crf_pkg::REG_W-1:0]  alu_res;
  logic                       alu_h;
  logic                       alu_n;
  logic                       alu_z;
  logic                       alu_v;
  logic                       alu_c;
  logic                       idle;
  logic                       op_go;
  logic                       flags_upd;
  logic                       res_wr;
  logic [7:0]                 next_cc;

  // Byte lanes touched by an access of a given size and selector.
  function automatic logic [3:0] lane_be(input logic [1:0] sz, input logic [3:0] sel);
    case (sz)
      crf_pkg::SZ_BYTE: lane_be = sel[3] ? 4'h1 : 4'h2;
      crf_pkg::SZ_WORD: lane_be = sel[3] ? 4'hC : 4'h3;
      default:          lane_be = 4'hF;
    endcase
  endfunction

  // Places a value in every lane so the enables pick the right one.
  function automatic logic [31:0] lane_data(input logic [1:0] sz, input logic [31:0] d);
    case (sz)
      crf_pkg::SZ_BYTE: lane_data = {4{d[7:0]}};
      crf_pkg::SZ_WORD: lane_data = {2{d[15:0]}};
      default:          lane_data = d;
    endcase
  endfunction

  // Pulls a zero-extended value of the chosen width out of a register.
  function automatic logic [31:0] lane_get(input logic [1:0] sz, input logic [3:0] sel,
                                           input logic [31:0] q);
    case (sz)
      crf_pkg::SZ_BYTE: lane_get = {24'h000000, sel[3] ? q[7:0] : q[15:8]};
      crf_pkg::SZ_WORD: lane_get = {16'h0000, sel[3] ? q[31:16] : q[15:0]};
      default:          lane_get = q;
    endcase
  endfunction

  assign idle = (state == crf_pkg::ST_IDLE);
  assign op_go = idle && op_start;
  assign busy = !idle;

  // Byte and word multiply and divide produce a destination twice the source width.
  assign dst_size = ((cur_op == crf_pkg::OP_MUL) || (cur_op == crf_pkg::OP_DIV))
                    ? 2'(cur_size + 2'h1) : cur_size;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state <= crf_pkg::ST_VECTOR;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      crf_pkg::ST_VECTOR:
      begin
        if (vec_ack)
          next_state = crf_pkg::ST_IDLE;
      end
      crf_pkg::ST_IDLE:
      begin
        if (op_start)
          next_state = crf_pkg::ST_EXEC;
        else if (sleep_cmd)
          next_state = crf_pkg::ST_SLEEP;
      end
      crf_pkg::ST_EXEC:
      begin
        if (cnt == 5'h00)
          next_state = crf_pkg::ST_IDLE;
      end
      crf_pkg::ST_SLEEP:
      begin
        if (irq_take || exc_entry)
          next_state = crf_pkg::ST_IDLE;
      end
      default: next_state = crf_pkg::ST_VECTOR;
    endcase
  end

  // Latches the operation and loads its length in states less two.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cnt         <= 5'h00;
      cur_op      <= crf_pkg::OP_ADD;
      cur_size    <= crf_pkg::SZ_BYTE;
      cur_dst     <= 4'h0;
      cur_src     <= 4'h0;
      cur_imm_sel <= 1'b0;
      cur_imm     <= '0;
    end
    else if (op_go)
    begin
      cur_op      <= op_code;
      cur_size    <= op_size;
      cur_dst     <= op_dst;
      cur_src     <= op_src;
      cur_imm_sel <= op_use_imm;
      cur_imm     <= op_imm;
      if ((op_code == crf_pkg::OP_MUL) || (op_code == crf_pkg::OP_DIV))
      begin
        if (op_size == crf_pkg::SZ_BYTE)
          cnt <= 5'(crf_pkg::STATES_MULDIV_BYTE - 5'h02);
        else
          cnt <= 5'(crf_pkg::STATES_MULDIV_WORD - 5'h02);
      end
      else
      begin
        cnt <= 5'(crf_pkg::STATES_ADDSUB - 5'h02);
      end
    end
    else if ((state == crf_pkg::ST_EXEC) && (cnt != 5'h00))
    begin
      cnt <= 5'(cnt - 5'h01);
    end
  end

  // Stack operations always address register seven; writes are full width, reads take the operation size.
  always_comb
  begin
    if (op_go && ((op_code == crf_pkg::OP_SPINC) || (op_code == crf_pkg::OP_SPDEC)))
      bank_a_idx = crf_pkg::SP_INDEX;
    else if (op_go)
      bank_a_idx = op_dst[2:0];
    else if (state == crf_pkg::ST_EXEC)
      bank_a_idx = cur_dst[2:0];
    else
      bank_a_idx = rd_sel[2:0];
    bank_b_idx = idle ? op_src[2:0] : cur_src[2:0];
  end

  assign alu_a = lane_get(dst_size, cur_dst, bank_a_q);
  assign alu_b = cur_imm_sel ? cur_imm : lane_get(cur_size, cur_src, bank_b_q);

  crf_alu u_alu (
    .op     (cur_op),
    .size   (cur_size),
    .opa    (alu_a),
    .opb    (alu_b),
    .result (alu_res),
    .flag_h (alu_h),
    .flag_n (alu_n),
    .flag_z (alu_z),
    .flag_v (alu_v),
    .flag_c (alu_c)
  );

  assign op_done = (state == crf_pkg::ST_EXEC) && (cnt == 5'h00);
  assign res_wr = op_done && (cur_op != crf_pkg::OP_CMP);
  assign flags_upd = op_done && (cur_op <= crf_pkg::OP_NEG);

  // The write port serves finished operations first, direct writes only when idle.
  always_comb
  begin
    bank_wr_idx  = wr_sel[2:0];
    bank_wr_be   = 4'h0;
    bank_wr_data = lane_data(wr_size, wr_data);
    if (res_wr && ((cur_op == crf_pkg::OP_SPINC) || (cur_op == crf_pkg::OP_SPDEC)))
    begin
      bank_wr_idx  = crf_pkg::SP_INDEX;
      bank_wr_be   = 4'hF;
      bank_wr_data = alu_res;
    end
    else if (res_wr)
    begin
      bank_wr_idx  = cur_dst[2:0];
      bank_wr_be   = lane_be(dst_size, cur_dst);
      bank_wr_data = lane_data(dst_size, alu_res);
    end
    else if (idle && wr_req && !op_start)
    begin
      bank_wr_be = lane_be(wr_size, wr_sel);
    end
  end

  crf_gpr_bank u_bank (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .wr_idx    (bank_wr_idx),
    .wr_be     (bank_wr_be),
    .wr_data   (bank_wr_data),
    .rd_a_idx  (bank_a_idx),
    .rd_b_idx  (bank_b_idx),
    .rd_a_data (bank_a_q),
    .rd_b_data (bank_b_q)
  );

  // Direct reads answer one clock after the request.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rd_valid  <= 1'b0;
      rd_sel_q  <= 4'h0;
      rd_size_q <= crf_pkg::SZ_BYTE;
    end
    else
    begin
      rd_valid  <= idle && rd_req && !op_start;
      rd_sel_q  <= rd_sel;
      rd_size_q <= rd_size;
    end
  end

  assign rd_data = lane_get(rd_size_q, rd_sel_q, bank_a_q);

  // Program counter.
  assign vec_req = (state == crf_pkg::ST_VECTOR);
  assign vec_addr = crf_pkg::RESET_VECTOR_ADDR;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pc <= '0;
    end
    else if (vec_req && vec_ack)
    begin
      pc <= vec_data;
    end
    else if (pc_load)
    begin
      pc <= pc_target;
    end
    else if (pc_step)
    begin
      pc <= 24'(pc + 24'h000002);
    end
  end

  // Only the low 64 kbytes are reachable, and fetches are word aligned.
  assign fetch_addr = {pc[crf_pkg::ADDR_W-1:1], 1'b0};

  // Condition-code register.
  always_comb
  begin
    next_cc = condition_code;
    if (idle && cc_wr)
    begin
      case (cc_op)
        crf_pkg::CC_LOAD: next_cc = cc_imm;
        crf_pkg::CC_AND:  next_cc = condition_code & cc_imm;
        crf_pkg::CC_OR:   next_cc = condition_code | cc_imm;
        default:          next_cc = condition_code ^ cc_imm;
      endcase
    end
    if (flags_upd)
    begin
      next_cc[crf_pkg::CC_H] = alu_h;
      next_cc[crf_pkg::CC_N] = alu_n;
      next_cc[crf_pkg::CC_Z] = alu_z;
      next_cc[crf_pkg::CC_V] = alu_v;
      next_cc[crf_pkg::CC_C] = alu_c;
    end
    if (exc_entry)
    begin
      next_cc[crf_pkg::CC_I] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      condition_code <= crf_pkg::CC_RESET;
    end
    else
    begin
      condition_code <= next_cc;
    end
  end

  assign irq_take = nmi_req || (irq_req && !condition_code[crf_pkg::CC_I]);
  assign power_down = (state == crf_pkg::ST_SLEEP);

  // Branch conditions from the four arithmetic flags.
  always_comb
  begin
    logic fn;
    logic fz;
    logic fv;
    logic fc;
    fn = condition_code[crf_pkg::CC_N];
    fz = condition_code[crf_pkg::CC_Z];
    fv = condition_code[crf_pkg::CC_V];
    fc = condition_code[crf_pkg::CC_C];
    case (branch_cond[3:1])
      3'h0:    branch_true = 1'b1;
      3'h1:    branch_true = !(fc || fz);
      3'h2:    branch_true = !fc;
      3'h3:    branch_true = !fz;
      3'h4:    branch_true = !fv;
      3'h5:    branch_true = !fn;
      3'h6:    branch_true = !(fn ^ fv);
      default: branch_true = !(fz || (fn ^ fv));
    endcase
    if (branch_cond[0])
      branch_true = !branch_true;
  end

endmodule

`default_nettype wire

// [crf_core_properties.sv]
// Concurrent checks on the ports of the register file core.
// Assumes the bind below attaches it to every crf_core instance.
`default_nettype none
module crf_props (
  input wire logic        sys_clk, rst_b, vec_req, vec_ack, busy, op_done, op_start,
  input wire logic        rd_req, rd_valid, sleep_cmd, power_down, exc_entry, cc_wr,
  input wire logic        irq_req, nmi_req, irq_take,
  input wire logic [2:0]  op_code,
  input wire logic [1:0]  op_size,
  input wire logic [23:0] vec_data, pc,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0]  condition_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic go = op_start && !busy;
  a_mask_gate: assert property (irq_take ==
    (nmi_req || (irq_req && !condition_code[7])))
    else $error("interrupt gate wrong");
  a_exc_mask: assert property (exc_entry |=> condition_code[7])
    else $error("mask bit not set on exception");
  a_fetch_even: assert property (fetch_addr == {pc[15:1], 1'b0})
    else $error("fetch address not even");
  a_reset_vals: assert property ($rose(rst_b) |-> condition_code == 8'h80 && vec_req)
    else $error("reset state wrong");
  a_vec_load: assert property (vec_req && vec_ack |=> pc == $past(vec_data) && !busy)
    else $error("vector not loaded");
  a_add_time: assert property (go && op_code == crf_pkg::OP_ADD
    |-> ##1 op_done ##1 !busy)
    else $error("add length wrong");
  a_mul_byte: assert property (go && op_code == crf_pkg::OP_MUL
    && op_size == crf_pkg::SZ_BYTE |-> ##13 op_done)
    else $error("byte multiply length wrong");
  a_div_word: assert property (go && op_code == crf_pkg::OP_DIV
    && op_size == crf_pkg::SZ_WORD |-> ##21 op_done ##1 !busy)
    else $error("word divide length wrong");
  a_rd_answer: assert property (rd_req && !busy && !op_start |=> rd_valid)
    else $error("read not answered");
  a_sleep_enter: assert property (sleep_cmd && !busy && !op_start |=> power_down)
    else $error("sleep not entered");
  a_cc_hold: assert property (!busy && !op_start && !cc_wr && !exc_entry
    |=> $stable(condition_code))
    else $error("flags changed unasked");
endmodule
bind crf_core crf_props u_props (.*);
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for crf_core: registers, flags, timing and sleep.
// Assumes crf_pkg, crf_core and the checker are compiled first.
`default_nettype none
`define CHK(n,e,a) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  int          seed = 32'hD0D92B3A;
  int          bad_count = 0;
  int          check_count = 0;
  int          w;
  logic        sys_clk = 0, rst_b = 0, vec_ack = 0, pc_load = 0, pc_step = 0, rd_req = 0;
  logic        wr_req = 0, op_start = 0, op_use_imm = 0, cc_wr = 0, exc_entry = 0;
  logic        irq_req = 0, nmi_req = 0, sleep_cmd = 0, vec_req, rd_valid, op_done, busy;
  logic        branch_true, irq_take, power_down;
  logic [23:0] vec_data = '0, pc_target = '0, pc;
  logic [15:0] vec_addr, fetch_addr;
  logic [3:0]  rd_sel = '0, wr_sel = '0, op_dst = '0, op_src = '0, branch_cond = '0, s;
  logic [2:0]  op_code = '0;
  logic [1:0]  rd_size = '0, wr_size = '0, op_size = '0, cc_op = '0, z;
  logic [31:0] wr_data = '0, op_imm = '0, rd_data, a, b, r, hm, hs;
  logic [32:0] sum;
  logic [7:0]  cc_imm = '0, condition_code, cc;
  logic [31:0] m [8] = '{default: '0};
  crf_core u_dut (.*);
  always #5 sys_clk = ~sys_clk;
  function automatic int sh(logic [3:0] t, logic [1:0] y);
    return y == 2'h0 ? (t[3] ? 0 : 8) : (y == 2'h1 && t[3]) ? 16 : 0;
  endfunction
  function automatic logic [31:0] mk(logic [1:0] y);
    return y == 2'h0 ? 32'h000000FF : y == 2'h1 ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction
  function automatic void put(logic [3:0] t, logic [1:0] y, logic [31:0] d);
    m[t[2:0]] = (m[t[2:0]] & ~(mk(y) << sh(t, y))) | ((d & mk(y)) << sh(t, y));
  endfunction
  function automatic logic bt(logic [3:0] k, logic [7:0] f);
    logic [7:0] t;
    t = {~(f[2] | (f[3] ^ f[1])), ~(f[3] ^ f[1]), ~f[3], ~f[1], ~f[2], ~f[0], ~(f[0] | f[2]), 1'b1};
    return t[k[3:1]] ^ k[0];
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(logic [3:0] t, logic [1:0] y, logic [31:0] d);
    @(posedge sys_clk);
    wr_req <= 1'b1; wr_sel <= t; wr_size <= y; wr_data <= d;
    @(posedge sys_clk);
    wr_req <= 1'b0;
    put(t, y, d);
  endtask
  task automatic rd(logic [3:0] t, logic [1:0] y);
    @(posedge sys_clk);
    rd_req <= 1'b1; rd_sel <= t; rd_size <= y;
    @(posedge sys_clk);
    rd_req <= 1'b0;
    #1 `CHK("rd_data", (m[t[2:0]] >> sh(t, y)) & mk(y), rd_data)
    `CHK("rd_valid", 1'b1, rd_valid)
  endtask
  task automatic op(logic [2:0] c, logic [1:0] y, logic [3:0] d, logic [31:0] v, int n);
    @(posedge sys_clk);
    op_start <= 1'b1; op_code <= c; op_size <= y; op_dst <= d; op_src <= d;
    op_use_imm <= 1'b1; op_imm <= v;
    @(posedge sys_clk);
    op_start <= 1'b0;
    repeat (n - 2) @(posedge sys_clk);
    #1 `CHK("op_done", 1'b1, op_done)
    @(posedge sys_clk);
    #1 `CHK("busy", 1'b0, busy)
  endtask
  task automatic ccw(logic [1:0] k, logic [7:0] e);
    @(posedge sys_clk);
    cc_wr <= 1'b1; cc_op <= k; cc_imm <= e;
    @(posedge sys_clk);
    cc_wr <= 1'b0;
    cc = k == 2'h0 ? e : k == 2'h1 ? cc & e : k == 2'h2 ? cc | e : cc ^ e;
    #1 `CHK("condition_code", cc, condition_code)
  endtask
  task automatic exc;
    @(posedge sys_clk);
    exc_entry <= 1'b1;
    @(posedge sys_clk);
    exc_entry <= 1'b0;
    cc[7] = 1'b1;
    #1 `CHK("mask bit", cc, condition_code)
  endtask
  task automatic irqs;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      {irq_req, nmi_req} <= i[1:0];
      #1 `CHK("irq_take", i[0] | (i[1] & ~cc[7]), irq_take)
    end
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1 `CHK("reset flags", 8'h80, condition_code)
    `CHK("vec_addr", crf_pkg::RESET_VECTOR_ADDR, vec_addr)
    a = $random(seed);
    @(posedge sys_clk);
    rst_b <= 1'b1; vec_ack <= 1'b1; vec_data <= a[23:0];
    @(posedge sys_clk);
    vec_ack <= 1'b0;
    #1 `CHK("vector pc", a[23:0], pc)
    a = $random(seed);
    @(posedge sys_clk);
    pc_load <= 1'b1; pc_target <= a[23:0];
    @(posedge sys_clk);
    pc_load <= 1'b0; pc_step <= 1'b1;
    @(posedge sys_clk);
    pc_step <= 1'b0;
    a = a + 32'h2;
    #1 `CHK("pc", a[23:0], pc)
    `CHK("fetch_addr", {a[15:1], 1'b0}, fetch_addr)
    $display("test reset and pc done");
    op(crf_pkg::OP_MUL, crf_pkg::SZ_BYTE, 4'h9, 32'h3, 14);
    op(crf_pkg::OP_DIV, crf_pkg::SZ_WORD, 4'h1, 32'h2, 22);
    $display("test long operations done");
    for (int i = 0; i < 8; i++)
      wr(i[3:0], crf_pkg::SZ_LONG, $random(seed));
    for (int i = 0; i < 24; i++)
    begin
      a = $random(seed);
      z = (a[1:0] == 2'h3) ? crf_pkg::SZ_LONG : a[1:0];
      wr(a[7:4], z, $random(seed));
      rd(a[7:4], z);
      rd(a[11:8], a[13:12] == 2'h3 ? 2'h2 : a[13:12]);
      rd({1'b0, a[6:4]}, crf_pkg::SZ_LONG);
    end
    op(crf_pkg::OP_SPINC, crf_pkg::SZ_LONG, 4'h7, 32'h4, 2);
    m[7] = m[7] + 32'h4;
    rd(4'h7, crf_pkg::SZ_LONG);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      z = 2'(i % 3);
      s = (z == crf_pkg::SZ_BYTE) ? 4'hA : 4'h2;
      w = 8 << z;
      a = (m[2] >> sh(s, z)) & mk(z);
      b = (i > 2) ? (~a + 32'h1) & mk(z) : $random(seed) & mk(z);
      sum = a + b;
      r = sum[31:0] & mk(z);
      hm = mk(z) >> 4;
      hs = (a & hm) + (b & hm);
      op(crf_pkg::OP_ADD, z, s, b, 2);
      put(s, z, r);
      rd(s, z);
      hm = {r[w-1], r == 0, a[w-1] == b[w-1] && r[w-1] != a[w-1], sum[w]};
      `CHK("half carry", hs[w-4], condition_code[5])
      `CHK("nzvc flags", hm[3:0], condition_code[3:0])
    end
    $display("test add flags done");
    for (int i = 0; i < 4; i++)
      ccw(i[1:0], $random(seed));
    exc;
    irqs;
    ccw(crf_pkg::CC_LOAD, 8'h44);
    irqs;
    @(posedge sys_clk);
    branch_cond <= 4'h6;
    #1 `CHK("branch ne", 1'b0, branch_true)
    @(posedge sys_clk);
    branch_cond <= 4'h7;
    #1 `CHK("branch eq", 1'b1, branch_true)
    for (int i = 0; i < 16; i++)
    begin
      ccw(crf_pkg::CC_LOAD, $random(seed));
      @(posedge sys_clk);
      branch_cond <= i[3:0];
      #1 `CHK("branch_true", bt(i[3:0], cc), branch_true)
    end
    $display("test flag register done");
    @(posedge sys_clk);
    sleep_cmd <= 1'b1;
    @(posedge sys_clk);
    sleep_cmd <= 1'b0;
    #1 `CHK("power_down", 1'b1, power_down)
    exc;
    `CHK("wake", 1'b0, power_down)
    $display("test sleep done");
    report_and_stop;
  end
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    bad_count++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule
`default_nettype wire
